/* File: dv/mgmt_host_model.sv */
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// management host: one register access at a time
// ----------------------------------------
module mgmt_host_model (
  input  wire logic        sys_clk,
  output logic      [4:0]  reg_addr,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [15:0] reg_wdata,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_rvalid
);
  initial begin
    reg_addr  = 5'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 16'h0000;
  end

  // write strobe held across the taking edge
  task automatic write_reg(input logic [4:0] addr, input logic [15:0] data);
    @(negedge sys_clk);
    reg_addr  = addr;
    reg_wdata = data;
    reg_wr    = 1'b1;
    @(negedge sys_clk);
    reg_wr    = 1'b0;
    reg_wdata = ~data;
  endtask

  // answer must stand half a cycle after the taking edge, else unknown
  task automatic read_reg(input logic [4:0] addr, output logic [15:0] data);
    @(negedge sys_clk);
    reg_addr = addr;
    reg_rd   = 1'b1;
    @(negedge sys_clk);
    data     = (reg_rvalid === 1'b1) ? reg_rdata : 16'hXXXX;
    reg_rd   = 1'b0;
    reg_addr = ~addr;
  endtask
endmodule

`default_nettype wire

/* File: dv/tb_phy_an_status_regs.sv */
`timescale 1ns/1ns
`default_nettype none

module tb_phy_an_status_regs;
  // arbitrary identifier values, then the fixed status word
  localparam logic [15:0] ID_HI_T = 16'h5A5A;
  localparam logic [15:0] ID_LO_T = 16'hC3C3;
  localparam logic [15:0] ST      = 16'h7949;

  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [4:0]  reg_addr;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic        reg_rvalid;
  logic        link_up = 1'b1;
  logic        jabber_event = 1'b0;
  logic        remote_fault_event = 1'b0;
  logic        an_complete = 1'b1;
  logic        an_enable = 1'b1;
  logic        an_restart_set = 1'b0;
  logic        an_restart_ack = 1'b0;
  logic [15:0] partner_word = 16'h0000;
  logic        partner_word_valid = 1'b0;
  logic        pause_default_strap_pin = 1'b1;
  logic [15:0] adv_word;
  logic        an_run;
  logic        an_restart_pending;
  int          errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  always #50 sys_clk = ~sys_clk;

  phy_an_status_regs #(.ID_HIGH(ID_HI_T), .ID_LOW(ID_LO_T)) dut_u (
    .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .link_up(link_up), .jabber_event(jabber_event), .remote_fault_event(remote_fault_event),
    .an_complete(an_complete), .an_enable(an_enable), .an_restart_set(an_restart_set),
    .an_restart_ack(an_restart_ack), .partner_word(partner_word),
    .partner_word_valid(partner_word_valid), .pause_default_strap_pin(pause_default_strap_pin),
    .adv_word(adv_word), .an_run(an_run), .an_restart_pending(an_restart_pending));

  mgmt_host_model host_u (
    .sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic give_verdict();
    if (errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      give_verdict();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [4:0] addr, input logic [15:0] exp);
    logic [15:0] d;
    host_u.read_reg(addr, d);
    chk(d, exp);
  endtask

  task automatic do_reset(input logic strap);
    @(negedge sys_clk);
    reset_n = 1'b0;
    pause_default_strap_pin = strap;
    repeat (6) @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (8) @(negedge sys_clk);
  endtask

  task automatic pulse_events(input logic jab, input logic flt, input logic link_drop);
    @(negedge sys_clk);
    jabber_event = jab;
    remote_fault_event = flt;
    link_up = ~link_drop;
    @(negedge sys_clk);
    jabber_event = 1'b0;
    remote_fault_event = 1'b0;
    link_up = 1'b1;
    repeat (2) @(negedge sys_clk);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_reset(input logic strap, input logic [15:0] exp);
    do_reset(strap);
    chk(adv_word, exp);
    rd_chk(phy_regs_pkg::ADDR_ADV, exp);
    chk({15'h0000, an_restart_pending}, 16'h0000);
  endtask

  task automatic test_ids();
    rd_chk(phy_regs_pkg::ADDR_ID_HIGH, ID_HI_T);
    rd_chk(phy_regs_pkg::ADDR_ID_LOW, ID_LO_T);
    host_u.write_reg(phy_regs_pkg::ADDR_ID_HIGH, 16'h0000);
    host_u.write_reg(phy_regs_pkg::ADDR_ID_LOW, 16'hFFFF);
    rd_chk(phy_regs_pkg::ADDR_ID_HIGH, ID_HI_T);
    rd_chk(phy_regs_pkg::ADDR_ID_LOW, ID_LO_T);
    rd_chk(5'h00, 16'h0000);
    rd_chk(5'h1F, 16'h0000);
  endtask

  task automatic test_status();
    rd_chk(phy_regs_pkg::ADDR_STATUS, ST | 16'h0020);
    rd_chk(phy_regs_pkg::ADDR_STATUS, ST | 16'h0024);
    pulse_events(1'b0, 1'b0, 1'b1);
    rd_chk(phy_regs_pkg::ADDR_STATUS, ST | 16'h0020);
    rd_chk(phy_regs_pkg::ADDR_STATUS, ST | 16'h0024);
    pulse_events(1'b1, 1'b0, 1'b0);
    rd_chk(phy_regs_pkg::ADDR_STATUS, ST | 16'h0026);
    rd_chk(phy_regs_pkg::ADDR_STATUS, ST | 16'h0024);
    pulse_events(1'b0, 1'b1, 1'b0);
    rd_chk(phy_regs_pkg::ADDR_STATUS, ST | 16'h0034);
    rd_chk(phy_regs_pkg::ADDR_STATUS, ST | 16'h0024);
  endtask

  task automatic test_adv();
    logic [15:0] w;
    host_u.write_reg(phy_regs_pkg::ADDR_ADV, 16'hFFFF);
    rd_chk(phy_regs_pkg::ADDR_ADV, 16'hADFF);
    host_u.write_reg(phy_regs_pkg::ADDR_ADV, 16'h5200);
    rd_chk(phy_regs_pkg::ADDR_ADV, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      w = {4'h0, i[1:0], 10'h021};
      host_u.write_reg(phy_regs_pkg::ADDR_ADV, w);
      chk(adv_word, w);
      rd_chk(phy_regs_pkg::ADDR_ADV, w);
    end
  endtask

  task automatic send_partner(input logic [15:0] w);
    @(negedge sys_clk);
    partner_word = w;
    partner_word_valid = 1'b1;
    @(negedge sys_clk);
    partner_word_valid = 1'b0;
    partner_word = ~w;
  endtask

  task automatic restart_pulse();
    @(negedge sys_clk);
    an_restart_set = 1'b1;
    @(negedge sys_clk);
    an_restart_set = 1'b0;
  endtask

  task automatic test_negotiation();
    send_partner(16'h85E1);
    rd_chk(phy_regs_pkg::ADDR_PARTNER, 16'hC5E1);
    send_partner(16'hFFFF);
    rd_chk(phy_regs_pkg::ADDR_PARTNER, 16'hEFFF);
    restart_pulse();
    chk({15'h0000, an_restart_pending}, 16'h0001);
    rd_chk(phy_regs_pkg::ADDR_PARTNER, 16'h0000);
    rd_chk(phy_regs_pkg::ADDR_STATUS, ST | 16'h0004);
    @(negedge sys_clk);
    an_restart_ack = 1'b1;
    @(negedge sys_clk);
    an_restart_ack = 1'b0;
    chk({15'h0000, an_restart_pending}, 16'h0000);
    rd_chk(phy_regs_pkg::ADDR_STATUS, ST | 16'h0024);
    @(negedge sys_clk);
    an_enable = 1'b0;
    @(negedge sys_clk);
    chk({15'h0000, an_run}, 16'h0000);
    restart_pulse();
    chk({15'h0000, an_restart_pending}, 16'h0000);
    send_partner(16'h05E1);
    rd_chk(phy_regs_pkg::ADDR_PARTNER, 16'h0000);
    rd_chk(phy_regs_pkg::ADDR_STATUS, ST | 16'h0004);
    an_enable = 1'b1;
    @(negedge sys_clk);
    chk({15'h0000, an_run}, 16'h0001);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    test_reset(1'b1, 16'h0DE1);
    test_ids();
    test_status();
    test_adv();
    test_negotiation();
    test_reset(1'b0, 16'h01E1);
    give_verdict();
  end
endmodule

`default_nettype wire

/* File: verilog/phy_an_status_regs.sv */
// What this block does
// - status bit 15 always reads zero
// - status bits 14 and 13 read one
// - status bits 12 and 11 read one
// - status bit 8 reads one, extended status
// - accept preambleless frames; status bit 6 one
// - status bit 5 shows negotiation finished
// - status bit 4 latches far-end fault until read
// - status bit 3 reads one, negotiation able
// - status bit 1 latches jabber until read
// - status bit 0 reads one, extended registers
// - read-only identifier words at 0x02, 0x03
// - advertisement bit 15 writable, resets zero
// - bit 13 writable zero reset; 14, 12 zero
// - pause field bits 11:10 writable, fixed encoding
// - pause field reset taken from strap pin
// - advertisement bit 9 reads zero
// - advertisement bits 8:5 writable, reset one
// - partner bit 14 set after word received
// - partner register read-only, same layout
// - negotiation runs only while enabled
// - restart request held until an_restart_ack
`timescale 1ns/1ns
`default_nettype none

module phy_an_status_regs #(
  parameter logic [15:0] ID_HIGH = 16'hA5C3, // arbitrary value
  parameter logic [15:0] ID_LOW  = 16'h3C5A  // arbitrary value
) (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic [4:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  output logic             reg_rvalid,
  input  wire logic        link_up,
  input  wire logic        jabber_event,
  input  wire logic        remote_fault_event,
  input  wire logic        an_complete,
  input  wire logic        an_enable,
  input  wire logic        an_restart_set,
  input  wire logic        an_restart_ack,
  input  wire logic [15:0] partner_word,
  input  wire logic        partner_word_valid,
  input  wire logic        pause_default_strap_pin,
  output logic      [15:0] adv_word,
  output logic             an_run,
  output logic             an_restart_pending
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    phy_regs_pkg::strap_state_t strap;
    logic [1:0]                 strap_cnt;
    logic [15:0]                adv;
    logic [15:0]                partner;
    logic                       fault;
    logic                       link_ok;
    logic                       jabber;
    logic                       run;
    logic                       restart;
    logic [15:0]                rdata;
    logic                       rvalid;
  } state_t;

  state_t state;
  state_t next_state;

  logic        strap_value;
  logic        strap_stable;
  logic        rd_status;
  logic        wr_adv;
  logic        an_done;
  logic [15:0] status_word;
  logic [15:0] read_word;

  // ----------------------------------------
  // strap synchroniser
  // ----------------------------------------
  pin_sync3 #(
    .WIDTH (1)
  ) u_strap_sync (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .pin     (pause_default_strap_pin),
    .value   (strap_value),
    .stable  (strap_stable)
  );

  // ----------------------------------------
  // decode and read mux
  // ----------------------------------------
  assign rd_status = reg_rd && (reg_addr == phy_regs_pkg::ADDR_STATUS);
  assign wr_adv    = reg_wr && (reg_addr == phy_regs_pkg::ADDR_ADV);
  assign an_done   = an_complete && state.run && !state.restart;

  always_comb begin
    status_word                             = phy_regs_pkg::STATUS_FIXED;
    status_word[phy_regs_pkg::ST_AN_DONE]   = an_done;
    status_word[phy_regs_pkg::ST_FAULT]     = state.fault || remote_fault_event;
    status_word[phy_regs_pkg::ST_LINK]      = state.link_ok && link_up;
    status_word[phy_regs_pkg::ST_JABBER]    = state.jabber || jabber_event;
  end

  always_comb begin
    case (reg_addr)
      phy_regs_pkg::ADDR_STATUS:  read_word = status_word;
      phy_regs_pkg::ADDR_ID_HIGH: read_word = ID_HIGH;
      phy_regs_pkg::ADDR_ID_LOW:  read_word = ID_LOW;
      phy_regs_pkg::ADDR_ADV:     read_word = state.adv;
      phy_regs_pkg::ADDR_PARTNER: read_word = state.partner & phy_regs_pkg::PARTNER_MASK;
      default:                    read_word = 16'h0000;
    endcase
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_state        = state;
    next_state.rvalid = reg_rd;
    if (reg_rd) begin
      next_state.rdata = read_word;
    end

    // latched events, the event wins over the read clear
    next_state.fault   = remote_fault_event || (state.fault && !rd_status);
    next_state.jabber  = jabber_event || (state.jabber && !rd_status);
    next_state.link_ok = link_up && (state.link_ok || rd_status);

    // strap capture once after reset release
    case (state.strap)
      phy_regs_pkg::STRAP_WAIT: begin
        if (state.strap_cnt != phy_regs_pkg::STRAP_SETTLE) begin
          next_state.strap_cnt = state.strap_cnt + 2'h1;
        end else if (strap_stable) begin
          next_state.adv[phy_regs_pkg::ADV_PAUSE_HI:phy_regs_pkg::ADV_PAUSE_LO] =
            strap_value ? phy_regs_pkg::PAUSE_BOTH : phy_regs_pkg::PAUSE_NONE;
          next_state.strap = phy_regs_pkg::STRAP_DONE;
        end
      end
      phy_regs_pkg::STRAP_DONE: begin
        next_state.strap = phy_regs_pkg::STRAP_DONE;
      end
      default: begin
        next_state.strap = phy_regs_pkg::STRAP_WAIT;
      end
    endcase

    // host write to the advertisement, reserved bits stay zero
    if (wr_adv) begin
      next_state.adv = reg_wdata & phy_regs_pkg::ADV_WR_MASK;
    end

    // negotiation run and restart
    next_state.run     = an_enable;
    next_state.restart = (an_restart_set && an_enable) || (state.restart && !an_restart_ack);

    // partner page capture
    if (an_restart_set || !state.run) begin
      next_state.partner = 16'h0000;
    end else if (partner_word_valid) begin
      next_state.partner                       = partner_word;
      next_state.partner[phy_regs_pkg::ADV_ACK] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state           <= '0;
      state.strap     <= phy_regs_pkg::STRAP_WAIT;
      state.adv       <= phy_regs_pkg::ADV_RESET;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign reg_rdata          = state.rdata;
  assign reg_rvalid         = state.rvalid;
  assign adv_word           = state.adv;
  assign an_run             = state.run;
  assign an_restart_pending = state.restart;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking

  default disable iff (!reset_n);

  a_t4_zero: assert property (rd_status |=> reg_rvalid && !reg_rdata[phy_regs_pkg::ST_T4])
    else $error("status bit 15 not zero");

  a_tx_caps: assert property (rd_status |=> reg_rdata[phy_regs_pkg::ST_TX_FD] && reg_rdata[phy_regs_pkg::ST_TX_HD])
    else $error("100 Mb/s capability bits not one");

  a_ten_caps: assert property (rd_status |=> reg_rdata[phy_regs_pkg::ST_TEN_FD] && reg_rdata[phy_regs_pkg::ST_TEN_HD])
    else $error("10 Mb/s capability bits not one");

  a_fixed_ones: assert property (rd_status |=> reg_rdata[phy_regs_pkg::ST_EXT_STATUS]
                                  && reg_rdata[phy_regs_pkg::ST_NO_PREAMBLE]
                                  && reg_rdata[phy_regs_pkg::ST_AN_ABLE]
                                  && reg_rdata[phy_regs_pkg::ST_EXT_CAP])
    else $error("fixed status capability bits wrong");

  a_an_done: assert property (rd_status |=> reg_rdata[phy_regs_pkg::ST_AN_DONE]
                               == $past(an_complete && an_run && !an_restart_pending))
    else $error("negotiation complete bit wrong");

  a_fault_held: assert property (remote_fault_event ##1 !rd_status [*3] ##1 rd_status
                                  |=> reg_rdata[phy_regs_pkg::ST_FAULT])
    else $error("remote fault not held until read");

  a_fault_set: assert property (remote_fault_event |=> state.fault)
    else $error("remote fault not latched");

  a_fault_clear: assert property (rd_status && !remote_fault_event ##1 !remote_fault_event
                                   ##1 rd_status && !remote_fault_event |=> !reg_rdata[phy_regs_pkg::ST_FAULT])
    else $error("remote fault not cleared by read");

  a_link_low: assert property (!link_up ##1 (link_up && !rd_status) [*3] ##1 rd_status
                                |=> !reg_rdata[phy_regs_pkg::ST_LINK])
    else $error("link loss not latched low");

  a_link_reload: assert property (rd_status && link_up ##1 link_up ##1 rd_status && link_up
                                   |=> reg_rdata[phy_regs_pkg::ST_LINK])
    else $error("link not reported after read");

  a_jabber_held: assert property (jabber_event ##1 !rd_status [*3] ##1 rd_status
                                   |=> reg_rdata[phy_regs_pkg::ST_JABBER])
    else $error("jabber not held until read");

  a_jabber_set: assert property (jabber_event |=> state.jabber)
    else $error("jabber not latched");

  a_jabber_clear: assert property (rd_status && !jabber_event ##1 !jabber_event
                                    ##1 rd_status && !jabber_event |=> !reg_rdata[phy_regs_pkg::ST_JABBER])
    else $error("jabber not cleared by read");

  a_id_words: assert property (reg_rd && reg_addr == phy_regs_pkg::ADDR_ID_LOW |=> reg_rdata == ID_LOW)
    else $error("identifier low word wrong");

  a_id_high: assert property (reg_rd && reg_addr == phy_regs_pkg::ADDR_ID_HIGH |=> reg_rdata == ID_HIGH)
    else $error("identifier high word wrong");

  a_adv_fixed: assert property (!adv_word[phy_regs_pkg::ADV_ACK]
                                 && !adv_word[phy_regs_pkg::ADV_RSVD]
                                 && !adv_word[phy_regs_pkg::ADV_T4])
    else $error("advertisement reserved bit set");

  a_adv_write: assert property (wr_adv && state.strap == phy_regs_pkg::STRAP_DONE
                                 |=> adv_word == ($past(reg_wdata) & phy_regs_pkg::ADV_WR_MASK))
    else $error("advertisement write not stored");

  a_strap_pause: assert property (state.strap == phy_regs_pkg::STRAP_DONE && !$past(wr_adv)
                                   && $past(state.strap) == phy_regs_pkg::STRAP_WAIT
                                   |-> adv_word[phy_regs_pkg::ADV_PAUSE_HI:phy_regs_pkg::ADV_PAUSE_LO]
                                   == ($past(strap_value) ? phy_regs_pkg::PAUSE_BOTH : phy_regs_pkg::PAUSE_NONE))
    else $error("pause field not taken from strap");

  a_partner_ack: assert property (partner_word_valid && an_run && !an_restart_set
                                   |=> state.partner[phy_regs_pkg::ADV_ACK])
    else $error("partner word not acknowledged");

  a_partner_clear: assert property (an_restart_set |=> state.partner == '0)
    else $error("partner word not cleared on restart");

  a_partner_mask: assert property (reg_rd && reg_addr == phy_regs_pkg::ADDR_PARTNER
                                    |=> !reg_rdata[phy_regs_pkg::ADV_RSVD])
    else $error("partner reserved bit set");

  a_run_gate: assert property (!an_enable |=> !an_run ##1 (!reg_rdata[phy_regs_pkg::ST_AN_DONE] || !reg_rvalid))
    else $error("negotiation reported while disabled");

  a_run_follow: assert property (an_enable |=> an_run)
    else $error("negotiation not running while enabled");

  a_restart_clear: assert property (an_restart_pending && an_restart_ack && !an_restart_set
                                     |=> !an_restart_pending)
    else $error("restart request did not clear");

  a_restart_set: assert property (an_restart_set && an_enable |=> an_restart_pending)
    else $error("restart request not taken");

  a_restart_refused: assert property (an_restart_set && !an_enable && !an_restart_pending
                                       |=> !an_restart_pending)
    else $error("restart taken while disabled");

  // ----------------------------------------
  // cover properties
  // ----------------------------------------

  c_status_read: cover property (rd_status ##1 reg_rvalid);
  c_adv_write:   cover property (wr_adv ##[1:4] reg_rd && reg_addr == phy_regs_pkg::ADDR_ADV);
  c_restart:     cover property (an_restart_set && an_enable ##[1:20] an_restart_ack);
  c_partner:     cover property (partner_word_valid && an_run ##[1:10] reg_rd && reg_addr == phy_regs_pkg::ADDR_PARTNER);
  c_link_drop:   cover property (!link_up ##[1:8] rd_status);

endmodule

`default_nettype wire

/* File: verilog/phy_regs_pkg.sv */
package phy_regs_pkg;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int REG_ADDR_W = 5;
  localparam int REG_DATA_W = 16;

  // ----------------------------------------
  // register addresses
  // ----------------------------------------
  localparam logic [4:0] ADDR_STATUS  = 5'h01;
  localparam logic [4:0] ADDR_ID_HIGH = 5'h02;
  localparam logic [4:0] ADDR_ID_LOW  = 5'h03;
  localparam logic [4:0] ADDR_ADV     = 5'h04;
  localparam logic [4:0] ADDR_PARTNER = 5'h05;

  // ----------------------------------------
  // status bit positions
  // ----------------------------------------
  localparam int ST_T4          = 15;
  localparam int ST_TX_FD       = 14;
  localparam int ST_TX_HD       = 13;
  localparam int ST_TEN_FD      = 12;
  localparam int ST_TEN_HD      = 11;
  localparam int ST_EXT_STATUS  = 8;
  localparam int ST_NO_PREAMBLE = 6;
  localparam int ST_AN_DONE     = 5;
  localparam int ST_FAULT       = 4;
  localparam int ST_AN_ABLE     = 3;
  localparam int ST_LINK        = 2;
  localparam int ST_JABBER      = 1;
  localparam int ST_EXT_CAP     = 0;

  // fixed capability bits 14,13,12,11,8,6,3,0
  localparam logic [15:0] STATUS_FIXED = 16'h7949;

  // ----------------------------------------
  // advertisement and partner layout
  // ----------------------------------------
  localparam int ADV_NEXT_PAGE = 15;
  localparam int ADV_ACK       = 14;
  localparam int ADV_FAULT     = 13;
  localparam int ADV_RSVD      = 12;
  localparam int ADV_PAUSE_HI  = 11;
  localparam int ADV_PAUSE_LO  = 10;
  localparam int ADV_T4        = 9;
  localparam int ADV_SEL_HI    = 4;

  localparam logic [15:0] ADV_RESET    = 16'h01E1;
  localparam logic [15:0] ADV_WR_MASK  = 16'hADFF;
  localparam logic [15:0] PARTNER_MASK = 16'hEFFF;
  localparam logic [4:0]  SEL_8023     = 5'h01;

  localparam logic [1:0] PAUSE_NONE = 2'h0;
  localparam logic [1:0] PAUSE_SYM  = 2'h1;
  localparam logic [1:0] PAUSE_ASYM = 2'h2;
  localparam logic [1:0] PAUSE_BOTH = 2'h3;

  // ----------------------------------------
  // strap sampling
  // ----------------------------------------
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  typedef enum logic [0:0] {
    STRAP_WAIT,
    STRAP_DONE
  } strap_state_t;

endpackage

/* File: verilog/pin_sync3.sv */
`timescale 1ns/1ns
`default_nettype none

module pin_sync3 #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] value,
  output logic                  stable
);

  // ----------------------------------------
  // three stage synchroniser
  // ----------------------------------------
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
  } sync_t;

  sync_t sync;
  sync_t next_sync;

  always_comb begin
    next_sync    = sync;
    next_sync.s1 = pin;
    next_sync.s2 = sync.s1;
    next_sync.s3 = sync.s2;
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      sync <= '0;
    end else begin
      sync <= next_sync;
    end
  end

  assign value  = sync.s3;
  assign stable = (sync.s2 == sync.s3);

endmodule

`default_nettype wire
